// ===== pkg/osm_map.vh
`ifndef OSM_MAP_VH
`define OSM_MAP_VH

// Register offsets on the serial bus
`define OSM_ON_THR_OFF    8'h2A
`define OSM_OFF_THR_OFF   8'h2B
`define OSM_AUTO_THR_OFF  8'h2C
`define OSM_MODE_OFF      8'h45
`define OSM_GEVT_A_OFF    8'h3E
`define OSM_GEVT_B_OFF    8'h40
`define OSM_GLED_OFS_OFF  8'h20
`define OSM_GLED_PER_OFF  8'h21
`define OSM_PLED_OFS_OFF  8'h22
`define OSM_PLED_PER_OFF  8'h23
`define OSM_STATUS_OFF    8'h50
`define OSM_INTENS_OFF    8'h51
`define OSM_POS_X_OFF     8'h52
`define OSM_POS_Y_OFF     8'h53

// Index of each writable register in the storage array
`define OSM_IDX_ON_THR    4'h0
`define OSM_IDX_OFF_THR   4'h1
`define OSM_IDX_AUTO_THR  4'h2
`define OSM_IDX_MODE      4'h3
`define OSM_IDX_GEVT_A    4'h4
`define OSM_IDX_GEVT_B    4'h5
`define OSM_IDX_GLED_OFS  4'h6
`define OSM_IDX_GLED_PER  4'h7
`define OSM_IDX_PLED_OFS  4'h8
`define OSM_IDX_PLED_PER  4'h9
`define OSM_IDX_NONE      4'hF
`define OSM_NUM_CFG       10

// Mode control field layout, plus the derivative select bit of gesture event register B
`define OSM_MODE_LSB      0
`define OSM_MODE_MSB      3
`define OSM_FMT_LSB       4
`define OSM_FMT_MSB       7
`define OSM_AUTO_EN_BIT   10
`define OSM_DERIV_SEL_BIT 0

// Mode field values
`define OSM_MODE_STANDBY  4'h0
`define OSM_MODE_PROX     4'h1
`define OSM_MODE_GEST     4'h8
`define OSM_MODE_IDLE_RD  4'hF

// Status bit positions
`define OSM_ST_ON_BIT     0
`define OSM_ST_OFF_BIT    1
`define OSM_ST_GEST_BIT   2
`define OSM_ST_AUTO_BIT   3

// Reset values
`define OSM_CFG_RST       16'h0000
`define OSM_STATUS_RST    4'h0
`define OSM_DEV_ADDR_RST  7'h64

`endif

// ===== core/osm_i2c_slave.v
`timescale 1ns/10ps
`include "osm_map.vh"

module osm_i2c_slave #(
   parameter [6:0] DEV_ADDR = `OSM_DEV_ADDR_RST
) (
   input  wire        sys_clk_i,
   input  wire        rst_n_i,
   input  wire        scl_i,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe_n_o,
   output reg         wr_o,
   output wire [7:0]  addr_o,
   output reg  [15:0] wdata_o,
   input  wire [15:0] rdata_i
);
   localparam [4:0] S_IDLE = 5'h01, S_RX = 5'h02, S_ACK = 5'h04, S_TX = 5'h08, S_TACK = 5'h10;

   reg [2:0] scl_q, sda_q;
   reg [4:0] state_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q, ptr_q, hi_q, lo_q;
   reg [1:0] idx_q;
   reg       rw_q, drive_q;

   // Two sync stages, then a third copy only for edge finding
   wire scl_rise = scl_q[1] & ~scl_q[2];
   wire scl_fall = ~scl_q[1] & scl_q[2];
   wire start_c  = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   wire stop_c   = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
   wire stby_wr  = (ptr_q == `OSM_MODE_OFF) && (sh_q[3:0] == `OSM_MODE_STANDBY);

   assign sda_o      = 1'b0;       // Open drain: only ever pulls low
   assign sda_oe_n_o = ~drive_q;
   assign addr_o     = ptr_q;

   // Pin synchronisers
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], scl_i};
         sda_q <= {sda_q[1:0], sda_i};
      end
   end

   // Byte engine: addr, pointer, then 16-bit words high byte first
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= S_IDLE;
         bit_q   <= 4'h0;
         sh_q    <= 8'h00;
         ptr_q   <= 8'h00;
         hi_q    <= 8'h00;
         lo_q    <= 8'h00;
         idx_q   <= 2'h0;
         rw_q    <= 1'b0;
         drive_q <= 1'b0;
         wr_o    <= 1'b0;
         wdata_o <= 16'h0000;
      end else begin
         wr_o <= 1'b0;
         if (start_c) begin
            state_q <= S_RX;
            bit_q   <= 4'h0;
            idx_q   <= 2'h0;
            drive_q <= 1'b0;
         end else if (stop_c) begin
            state_q <= S_IDLE;
            drive_q <= 1'b0;
         end else begin
            case (state_q)
               S_RX: begin
                  if (scl_rise) begin
                     sh_q  <= {sh_q[6:0], sda_q[1]};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     state_q <= S_ACK;
                     drive_q <= 1'b1;
                     case (idx_q)
                        2'h0: begin
                           rw_q <= sh_q[0];
                           if (sh_q[7:1] != DEV_ADDR) begin
                              state_q <= S_IDLE;
                              drive_q <= 1'b0;
                           end
                        end
                        2'h1: ptr_q <= sh_q;
                        2'h2: hi_q  <= sh_q;
                        default: begin
                           wr_o    <= 1'b1;
                           wdata_o <= {hi_q, sh_q};
                           drive_q <= ~stby_wr;
                        end
                     endcase
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (idx_q == 2'h0 && rw_q) begin
                        sh_q    <= rdata_i[15:8];
                        lo_q    <= rdata_i[7:0];
                        drive_q <= ~rdata_i[15];
                        bit_q   <= 4'h1;
                        idx_q   <= 2'h2;
                        state_q <= S_TX;
                     end else begin
                        drive_q <= 1'b0;
                        state_q <= S_RX;
                        idx_q   <= (idx_q == 2'h3) ? 2'h2 : idx_q + 2'h1;
                        if (idx_q == 2'h3)
                           ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h8) begin
                        drive_q <= 1'b0;
                        state_q <= S_TACK;
                     end else begin
                        drive_q <= ~sh_q[6];
                        sh_q    <= {sh_q[6:0], 1'b0};
                        bit_q   <= bit_q + 4'h1;
                     end
                  end
               end
               S_TACK: begin
                  if (scl_rise && sda_q[1]) begin
                     state_q <= S_IDLE;   // Master nack ends the read
                  end else if (scl_fall) begin
                     bit_q   <= 4'h1;
                     state_q <= S_TX;
                     if (idx_q == 2'h2) begin
                        sh_q    <= lo_q;
                        drive_q <= ~lo_q[7];
                        idx_q   <= 2'h3;
                        ptr_q   <= ptr_q + 8'h01;
                     end else begin
                        sh_q    <= rdata_i[15:8];
                        lo_q    <= rdata_i[7:0];
                        drive_q <= ~rdata_i[15];
                        idx_q   <= 2'h2;
                     end
                  end
               end
               default: begin
                  drive_q <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ===== core/osm_mode_ctrl.v
// Notes on behaviour
// - After power-up the block sits in idle with no host command.
// - Idle holds until the host writes standby, proximity or gesture mode.
// - Mode field value 0x0 selects standby; all data collection then stops.
// - The write entering standby is not acknowledged; host must accept that.
// - In standby any write to the mode control register wakes the block.
// - Standby keeps every configuration and data register unchanged.
// - Mode field 0x1 selects proximity, LED driven from the proximity timing set.
// - Proximity intensity is the sum of the four channel results.
// - Interrupt when intensity rises above the on threshold.
// - Interrupt when intensity falls below the off threshold, giving hysteresis.
// - After a proximity event intensity and x, y position are readable.
// - Output FIFO data format comes from mode control register fields.
// - Mode field value 0x8 selects sample/gesture mode.
// - Gesture mode uses its own LED timing set, separate from proximity.
// - Gesture coordinate capture is triggered by the two gesture event registers.
// - An interrupt can flag the start of a potential gesture.
// - Gesture trigger selects absolute intensity or its derivative.
// - Proximity intensity reaching the 16-bit auto threshold switches to gesture mode.
// - Auto switch only when mode bit 10 is set and proximity is started.
`timescale 1ns/10ps
`include "osm_map.vh"

module osm_mode_ctrl #(
   parameter [6:0] DEV_ADDR = `OSM_DEV_ADDR_RST,
   parameter       CH_W     = 16
) (
   input  wire            sys_clk_i,
   input  wire            rst_n_i,
   input  wire            scl_i,
   input  wire            sda_i,
   output wire            sda_o,
   output wire            sda_oe_n_o,
   output reg             int_o,
   input  wire            sample_valid_i,
   input  wire [CH_W-1:0] ch0_i,
   input  wire [CH_W-1:0] ch1_i,
   input  wire [CH_W-1:0] ch2_i,
   input  wire [CH_W-1:0] ch3_i,
   input  wire [15:0]     pos_x_i,
   input  wire [15:0]     pos_y_i,
   output reg             acq_run_o,
   output reg             gest_set_o,
   output reg  [5:0]      led_offset_o,
   output reg  [7:0]      led_period_o,
   output reg  [3:0]      fifo_fmt_o
);
   // Operating states
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_STBY = 4'b0010;
   localparam [3:0] ST_PROX = 4'b0100;
   localparam [3:0] ST_GEST = 4'b1000;

   reg  [3:0]  state_q, state_d;
   reg  [15:0] cfg_q [0:`OSM_NUM_CFG-1];
   reg  [3:0]  status_q;
   reg  [3:0]  status_d;
   reg  [15:0] intens_q;
   reg  [15:0] prev_q;
   reg  [15:0] pos_x_q;
   reg  [15:0] pos_y_q;
   reg         near_q;
   reg         armed_q;
   reg  [15:0] rdata_c;

   wire        wr;
   wire [7:0]  addr;
   wire [15:0] wdata;

   // Map a bus offset onto the storage index; used by write and read paths
   function [3:0] cfg_index;
      input [7:0] a;
      begin
         case (a)
            `OSM_ON_THR_OFF:   cfg_index = `OSM_IDX_ON_THR;
            `OSM_OFF_THR_OFF:  cfg_index = `OSM_IDX_OFF_THR;
            `OSM_AUTO_THR_OFF: cfg_index = `OSM_IDX_AUTO_THR;
            `OSM_MODE_OFF:     cfg_index = `OSM_IDX_MODE;
            `OSM_GEVT_A_OFF:   cfg_index = `OSM_IDX_GEVT_A;
            `OSM_GEVT_B_OFF:   cfg_index = `OSM_IDX_GEVT_B;
            `OSM_GLED_OFS_OFF: cfg_index = `OSM_IDX_GLED_OFS;
            `OSM_GLED_PER_OFF: cfg_index = `OSM_IDX_GLED_PER;
            `OSM_PLED_OFS_OFF: cfg_index = `OSM_IDX_PLED_OFS;
            `OSM_PLED_PER_OFF: cfg_index = `OSM_IDX_PLED_PER;
            default:           cfg_index = `OSM_IDX_NONE;
         endcase
      end
   endfunction

   // Mode field value shown for the running state
   function [3:0] mode_code;
      input [3:0] st;
      begin
         case (st)
            ST_STBY: mode_code = `OSM_MODE_STANDBY;
            ST_PROX: mode_code = `OSM_MODE_PROX;
            ST_GEST: mode_code = `OSM_MODE_GEST;
            default: mode_code = `OSM_MODE_IDLE_RD;
         endcase
      end
   endfunction

   // Serial register port
   osm_i2c_slave #(
      .DEV_ADDR (DEV_ADDR)
   ) u_i2c (
      .sys_clk_i  (sys_clk_i),
      .rst_n_i    (rst_n_i),
      .scl_i      (scl_i),
      .sda_i      (sda_i),
      .sda_o      (sda_o),
      .sda_oe_n_o (sda_oe_n_o),
      .wr_o       (wr),
      .addr_o     (addr),
      .wdata_o    (wdata),
      .rdata_i    (rdata_c)
   );

   wire        mode_wr   = wr && (addr == `OSM_MODE_OFF);
   wire [3:0]  mode_fld  = wdata[`OSM_MODE_MSB:`OSM_MODE_LSB];
   wire [15:0] mode_reg  = cfg_q[`OSM_IDX_MODE];
   wire [15:0] on_thr    = cfg_q[`OSM_IDX_ON_THR];
   wire [15:0] off_thr   = cfg_q[`OSM_IDX_OFF_THR];
   wire [15:0] auto_thr  = cfg_q[`OSM_IDX_AUTO_THR];
   wire [15:0] gest_lvl  = cfg_q[`OSM_IDX_GEVT_A];
   wire        deriv_sel = cfg_q[`OSM_IDX_GEVT_B][`OSM_DERIV_SEL_BIT];
   wire        auto_en   = mode_reg[`OSM_AUTO_EN_BIT];
   wire        in_prox   = (state_q == ST_PROX);
   wire        in_gest   = (state_q == ST_GEST);

   wire [CH_W+1:0] sum_w = {2'b00, ch0_i} + {2'b00, ch1_i} + {2'b00, ch2_i} + {2'b00, ch3_i};
   // Saturate so a bright return never wraps and fakes an off event
   wire [15:0] intens_w = (|sum_w[CH_W+1:16]) ? 16'hFFFF : sum_w[15:0];
   wire        smp_prox = sample_valid_i && in_prox;
   wire        smp_gest = sample_valid_i && in_gest;

   wire ev_on   = smp_prox && !near_q && (intens_w > on_thr);
   wire ev_off  = smp_prox && near_q && (intens_w < off_thr);
   wire ev_auto = smp_prox && auto_en && (intens_w >= auto_thr);

   wire [15:0] delta_w = intens_w - prev_q;
   wire        rising  = intens_w > prev_q;
   wire        trig    = deriv_sel ? (rising && (delta_w > gest_lvl)) : (intens_w > gest_lvl);
   wire        ev_cap  = smp_gest && trig;
   wire        ev_gst  = ev_cap && !armed_q;

   // Writable configuration storage, one slot per index
   genvar gi;
   generate
      for (gi = 0; gi < `OSM_NUM_CFG; gi = gi + 1) begin : g_cfg
         always @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cfg_q[gi] <= `OSM_CFG_RST;
            end else if (wr && cfg_index(addr) == gi) begin
               cfg_q[gi] <= wdata;
            end
         end
      end
   endgenerate

   // Next operating state
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (mode_wr) begin
               case (mode_fld)
                  `OSM_MODE_STANDBY: state_d = ST_STBY;
                  `OSM_MODE_PROX:    state_d = ST_PROX;
                  `OSM_MODE_GEST:    state_d = ST_GEST;
                  default:           state_d = ST_IDLE;
               endcase
            end
         end
         ST_STBY: begin
            if (mode_wr) begin
               case (mode_fld)
                  `OSM_MODE_PROX: state_d = ST_PROX;
                  `OSM_MODE_GEST: state_d = ST_GEST;
                  default:        state_d = ST_IDLE;
               endcase
            end
         end
         ST_PROX, ST_GEST: begin
            if (mode_wr) begin
               case (mode_fld)
                  `OSM_MODE_STANDBY: state_d = ST_STBY;
                  `OSM_MODE_PROX:    state_d = ST_PROX;
                  `OSM_MODE_GEST:    state_d = ST_GEST;
                  default:           state_d = ST_IDLE;
               endcase
            end else if (in_prox && ev_auto) begin
               state_d = ST_GEST;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Event status: a write of one clears, a new event in the same cycle wins
   always @* begin
      status_d = status_q;
      if (wr && addr == `OSM_STATUS_OFF) begin
         status_d = status_q & ~wdata[3:0];
      end
      status_d[`OSM_ST_ON_BIT]   = status_d[`OSM_ST_ON_BIT] | ev_on;
      status_d[`OSM_ST_OFF_BIT]  = status_d[`OSM_ST_OFF_BIT] | ev_off;
      status_d[`OSM_ST_GEST_BIT] = status_d[`OSM_ST_GEST_BIT] | ev_gst;
      status_d[`OSM_ST_AUTO_BIT] = status_d[`OSM_ST_AUTO_BIT] | (in_prox && ev_auto && !mode_wr);
   end

   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_q <= `OSM_STATUS_RST;
         int_o    <= 1'b0;
      end else begin
         status_q <= status_d;
         int_o    <= |status_d;
      end
   end

   // Hysteresis and gesture arming flags
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         near_q  <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         if (ev_on) begin
            near_q <= 1'b1;
         end else if (ev_off) begin
            near_q <= 1'b0;
         end
         if (smp_gest) begin
            armed_q <= trig;   // Re-arms once the trigger drops away
         end
      end
   end

   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         intens_q <= 16'h0000;
         prev_q   <= 16'h0000;
         pos_x_q  <= 16'h0000;
         pos_y_q  <= 16'h0000;
      end else begin
         if (smp_prox || smp_gest) begin
            intens_q <= intens_w;
            prev_q   <= intens_w;
         end
         if (ev_on || ev_off || ev_cap) begin
            pos_x_q <= pos_x_i;
            pos_y_q <= pos_y_i;
         end
      end
   end

   // Outputs towards the LED timing core and FIFO formatter
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acq_run_o    <= 1'b0;
         gest_set_o   <= 1'b0;
         led_offset_o <= 6'h00;
         led_period_o <= 8'h00;
         fifo_fmt_o   <= 4'h0;
      end else begin
         acq_run_o  <= (state_d == ST_PROX) || (state_d == ST_GEST);
         gest_set_o <= (state_d == ST_GEST);
         if (state_d == ST_GEST) begin
            led_offset_o <= cfg_q[`OSM_IDX_GLED_OFS][5:0];
            led_period_o <= cfg_q[`OSM_IDX_GLED_PER][7:0];
         end else begin
            led_offset_o <= cfg_q[`OSM_IDX_PLED_OFS][5:0];
            led_period_o <= cfg_q[`OSM_IDX_PLED_PER][7:0];
         end
         fifo_fmt_o <= mode_reg[`OSM_FMT_MSB:`OSM_FMT_LSB];
      end
   end

   // Read data; the mode field reports the live state, not the last write
   always @* begin
      rdata_c = 16'h0000;
      case (addr)
         `OSM_STATUS_OFF: rdata_c = {12'h000, status_q};
         `OSM_INTENS_OFF: rdata_c = intens_q;
         `OSM_POS_X_OFF:  rdata_c = pos_x_q;
         `OSM_POS_Y_OFF:  rdata_c = pos_y_q;
         `OSM_MODE_OFF:   rdata_c = {mode_reg[15:4], mode_code(state_q)};
         default: begin
            if (cfg_index(addr) != `OSM_IDX_NONE) begin
               rdata_c = cfg_q[cfg_index(addr)];
            end
         end
      endcase
   end
endmodule

// ===== sim/osm_mode_ctrl_chk.sv
`timescale 1ns/10ps
module osm_mode_ctrl_chk (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire scl_i,
   input wire sda_oe_n_o,
   input wire int_o,
   input wire sample_valid_i,
   input wire acq_run_o,
   input wire gest_set_o
);
   reg [3:0] scl_hi_q;
   wire      host_near;

   // Cycles since SCL was low; host writes land only just after a fall
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_hi_q <= 4'hF;
      end else if (!scl_i) begin
         scl_hi_q <= 4'h0;
      end else if (scl_hi_q != 4'hF) begin
         scl_hi_q <= scl_hi_q + 4'h1;
      end
   end
   assign host_near = (scl_hi_q < 4'h8);

   default clocking dcb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_idle_at_start: assert property ($rose(rst_n_i) |-> !acq_run_o && !int_o)
      else $error("block not idle after reset");
   chk_run_by_write: assert property ($rose(acq_run_o) |-> host_near)
      else $error("acquisition began without a host write");
   chk_stop_by_write: assert property ($fell(acq_run_o) |-> host_near)
      else $error("acquisition stopped without a host write");
   chk_ack_scl_low: assert property ($changed(sda_oe_n_o) |-> !$past(scl_i, 3))
      else $error("data line moved while clock high");
   chk_gest_in_run: assert property (gest_set_o |-> acq_run_o)
      else $error("gesture set without acquisition");
   chk_int_by_sample: assert property ($rose(int_o) |-> $past(sample_valid_i) ||
      $past(sample_valid_i, 2))
      else $error("interrupt rose without a sample");
   chk_int_held: assert property ($fell(int_o) |-> host_near)
      else $error("interrupt dropped without a host clear");
   chk_auto_cause: assert property ($rose(gest_set_o) |-> host_near ||
      $past(sample_valid_i) || $past(sample_valid_i, 2))
      else $error("gesture mode without write or sample");

   // Main scenarios reached
   cov_int_cycle: cover property (int_o ##1 !int_o);
   cov_auto_switch: cover property ($rose(gest_set_o) && $past(sample_valid_i));
   cov_standby: cover property ($fell(acq_run_o));
endmodule

bind osm_mode_ctrl osm_mode_ctrl_chk u_chk (
   .sys_clk_i      (sys_clk_i),
   .rst_n_i        (rst_n_i),
   .scl_i          (scl_i),
   .sda_oe_n_o     (sda_oe_n_o),
   .int_o          (int_o),
   .sample_valid_i (sample_valid_i),
   .acq_run_o      (acq_run_o),
   .gest_set_o     (gest_set_o)
);

// ===== sim/osm_host_bfm.sv
`timescale 1ns/10ps
module osm_host_bfm #(
   parameter [6:0] DEV_ADDR = 7'h64
) (
   input  wire clk_i,
   input  wire sda_i,
   output reg  scl_o,
   output reg  sda_low_o
);
   // Bus idles released with SCL high; the pull-up sets the level
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // Eight clocks per bit; data moves only while SCL is low
   task bit_x(input b, output r);
      begin
         @(posedge clk_i) sda_low_o <= !b;
         repeat (3) @(posedge clk_i);
         scl_o <= 1'b1;
         repeat (2) @(posedge clk_i);
         @(negedge clk_i) r = sda_i;
         repeat (2) @(posedge clk_i);
         scl_o <= 1'b0;
      end
   endtask

   // Long lead so the slave has released a pending ack first
   task start_c;
      begin
         @(posedge clk_i) sda_low_o <= 1'b0;
         repeat (4) @(posedge clk_i);
         scl_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         sda_low_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         scl_o <= 1'b0;
      end
   endtask

   task stop_c;
      begin
         @(posedge clk_i) sda_low_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         scl_o <= 1'b1;
         repeat (3) @(posedge clk_i);
         sda_low_o <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
   endtask

   task tx(input [7:0] d, output ack);
      integer i;
      reg     r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_x(d[i], r);
         end
         bit_x(1'b1, r);
         ack = !r;
      end
   endtask

   task rx(input last, output [7:0] d);
      integer i;
      reg     r;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            bit_x(1'b1, r);
            d = {d[6:0], r};
         end
         bit_x(last, r);
      end
   endtask

   // Ack of the low byte is handed back, never acted on
   task write_reg(input [7:0] ptr, input [15:0] data, output ack);
      begin
         start_c;
         tx({DEV_ADDR, 1'b0}, ack);
         tx(ptr, ack);
         tx(data[15:8], ack);
         tx(data[7:0], ack);
         stop_c;
      end
   endtask

   task read_reg(input [7:0] ptr, output [15:0] data);
      reg ack;
      begin
         start_c;
         tx({DEV_ADDR, 1'b0}, ack);
         tx(ptr, ack);
         start_c;
         tx({DEV_ADDR, 1'b1}, ack);
         rx(1'b0, data[15:8]);
         rx(1'b1, data[7:0]);
         stop_c;
      end
   endtask
endmodule

// ===== sim/osm_mode_ctrl_tb.sv
`timescale 1ns/10ps
module osm_mode_ctrl_tb;
   reg         clk;
   reg         rst_n;
   reg         valid;
   reg  [15:0] c0;
   reg  [15:0] c1;
   reg  [15:0] px;
   reg  [15:0] py;
   wire        scl;
   wire        host_low;
   wire        sda_o;
   wire        sda_oe_n;
   wire        sda;
   wire        intr;
   wire        acq;
   wire        gest;
   wire [5:0]  led_ofs;
   wire [7:0]  led_per;
   wire [3:0]  fmt;
   integer     num_errors;
   integer     total_checks;
   integer     i;

   // Open-drain line with pull-up
   assign sda = !(host_low || (!sda_oe_n && !sda_o));

   osm_mode_ctrl uut (
      .sys_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n), .int_o(intr), .sample_valid_i(valid), .ch0_i(c0),
      .ch1_i(c1), .ch2_i(c1), .ch3_i(c1), .pos_x_i(px), .pos_y_i(py),
      .acq_run_o(acq), .gest_set_o(gest), .led_offset_o(led_ofs),
      .led_period_o(led_per), .fifo_fmt_o(fmt)
   );

   osm_host_bfm host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task close_out;
      begin
         $display("checks %0d errors %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (90000) @(posedge clk);
      num_errors = num_errors + 1;
      close_out;
   end

   task check(input [15:0] seen, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   task flag(input s, input e);
      check({15'h0000, s}, {15'h0000, e});
   endtask

   task wr(input [7:0] a, input [15:0] d, input ack_exp);
      reg ack;
      begin
         host.write_reg(a, d, ack);
         flag(ack, ack_exp);
      end
   endtask

   task rd(input [7:0] a, input [15:0] exp);
      reg [15:0] v;
      begin
         host.read_reg(a, v);
         check(v, exp);
      end
   endtask

   // One sample: sum is a + 3b, position (a, b)
   task sample(input [15:0] a, input [15:0] b);
      begin
         @(posedge clk);
         c0 <= a;
         c1 <= b;
         px <= a;
         py <= b;
         valid <= 1'b1;
         @(posedge clk) valid <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      valid = 1'b0;
      c0 = 16'h0000;
      c1 = 16'h0000;
      px = 16'h0000;
      py = 16'h0000;
      num_errors = 0;
      total_checks = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      // Power-up state and idle deafness to samples
      rd(8'h45, 16'h000F);
      for (i = 0; i < 3; i = i + 1) rd(8'h2A + i, 16'h0000);
      sample(16'h4000, 16'h4000);
      flag(intr | acq, 1'b0);
      // Thresholds, timing sets, trigger, unmapped place
      wr(8'h2A, 16'h0100, 1'b1);
      wr(8'h2B, 16'h0080, 1'b1);
      wr(8'h2C, 16'h0800, 1'b1);
      wr(8'h20, 16'h0011, 1'b1);
      wr(8'h21, 16'h0022, 1'b1);
      wr(8'h22, 16'h0005, 1'b1);
      wr(8'h23, 16'h0006, 1'b1);
      wr(8'h3E, 16'h0200, 1'b1);
      wr(8'h7F, 16'hBEEF, 1'b1);
      rd(8'h7F, 16'h0000);
      rd(8'h2C, 16'h0800);
      // Proximity: on threshold boundary, hold, clear, off threshold
      wr(8'h45, 16'h0031, 1'b1);
      check({10'h000, gest, acq, fmt}, 16'h0013);
      check({2'b00, led_ofs, led_per}, 16'h0506);
      sample(16'h0040, 16'h0040);
      flag(intr, 1'b0);
      sample(16'h0041, 16'h0040);
      flag(intr, 1'b1);
      rd(8'h51, 16'h0101);
      rd(8'h52, 16'h0041);
      rd(8'h53, 16'h0040);
      rd(8'h50, 16'h0001);
      sample(16'h0040, 16'h0040);
      flag(intr, 1'b1);
      wr(8'h50, 16'h0001, 1'b1);
      flag(intr, 1'b0);
      sample(16'h0020, 16'h0020);
      flag(intr, 1'b0);
      sample(16'h001F, 16'h0020);
      flag(intr, 1'b1);
      rd(8'h50, 16'h0002);
      wr(8'h50, 16'h0002, 1'b1);
      // Standby: refused ack, retention, no collection, wake
      wr(8'h45, 16'h0030, 1'b0);
      flag(acq, 1'b0);
      sample(16'h4000, 16'h4000);
      flag(intr, 1'b0);
      rd(8'h51, 16'h007F);
      rd(8'h2A, 16'h0100);
      rd(8'h45, 16'h0030);
      wr(8'h45, 16'h0000, 1'b0);
      rd(8'h45, 16'h000F);
      // Gesture: own timing set, absolute then derivative trigger
      wr(8'h45, 16'h0008, 1'b1);
      check({14'h0000, gest, acq}, 16'h0003);
      check({2'b00, led_ofs, led_per}, 16'h1122);
      sample(16'h0040, 16'h0040);
      flag(intr, 1'b0);
      sample(16'h0100, 16'h0100);
      flag(intr, 1'b1);
      rd(8'h52, 16'h0100);
      wr(8'h50, 16'h000F, 1'b1);
      wr(8'h40, 16'h0001, 1'b1);
      sample(16'h0100, 16'h0100);
      flag(intr, 1'b0);
      sample(16'h0200, 16'h0200);
      flag(intr, 1'b1);
      wr(8'h50, 16'h000F, 1'b1);
      // Auto switch only with its enable bit, at the threshold itself
      wr(8'h45, 16'h0001, 1'b1);
      sample(16'h0200, 16'h0200);
      flag(gest, 1'b0);
      wr(8'h50, 16'h000F, 1'b1);
      wr(8'h45, 16'h0401, 1'b1);
      sample(16'h01FF, 16'h0200);
      flag(gest, 1'b0);
      sample(16'h0200, 16'h0200);
      flag(gest, 1'b1);
      rd(8'h45, 16'h0408);
      close_out;
   end
endmodule
